// >>> logic/amc_cfg.svh
// offsets, bit positions, reset values and codes of the converter control
`ifndef AMC_CFG_SVH
`define AMC_CFG_SVH
`define AMC_IDX_MAIN   16'h1D26
`define AMC_IDX_DIV    16'h1D2A
`define AMC_IDX_SOI    16'h1D2B
`define AMC_IDX_RES    16'h1D2C
`define AMC_IDX_PREV   16'h1D2D
`define AMC_IDX_STAT   16'h1D2E
`define AMC_IDX_EN     16'h1D2F
`define AMC_IDX_CLR    16'h1D30
`define AMC_A_MAIN     (`AMC_IDX_MAIN << 2)
`define AMC_A_DIV      (`AMC_IDX_DIV << 2)
`define AMC_A_SOI      (`AMC_IDX_SOI << 2)
`define AMC_A_RES      (`AMC_IDX_RES << 2)
`define AMC_A_PREV     (`AMC_IDX_PREV << 2)
`define AMC_A_STAT     (`AMC_IDX_STAT << 2)
`define AMC_A_EN       (`AMC_IDX_EN << 2)
`define AMC_A_CLR      (`AMC_IDX_CLR << 2)
`define AMC_MAIN_RST   8'h00
`define AMC_B_ON       7
`define AMC_B_REPEAT   6
`define AMC_B_CS       4
`define AMC_B_FMT      2
`define AMC_B_GO       0
`define AMC_EV_DONE    0
`define AMC_EV_THR     1
`define AMC_EV_ABORT   2
`define AMC_RESP_OK    2'h0
`define AMC_RESP_ERR   2'h2
`define AMC_RES_W      10
`define AMC_DIV_W      6
`endif

// >>> logic/amc_pkg.sv
// types and address decode shared by the converter control modules
`include "amc_cfg.svh"
package amc_pkg;
	typedef enum logic [3:0] {
		AMC_R_NONE = 4'h0,
		AMC_R_MAIN = 4'h1,
		AMC_R_DIV  = 4'h2,
		AMC_R_SOI  = 4'h3,
		AMC_R_RES  = 4'h4,
		AMC_R_PREV = 4'h5,
		AMC_R_STAT = 4'h6,
		AMC_R_EN   = 4'h7,
		AMC_R_CLR  = 4'h8
	} amc_reg_e;

	typedef enum logic {
		AMC_S_IDLE = 1'h0,
		AMC_S_CONV = 1'h1
	} amc_seq_st_e;

	// byte address to register select
	function automatic amc_reg_e amc_decode(input logic [15:0] a);
		case (a)
			`AMC_A_MAIN: amc_decode = AMC_R_MAIN;
			`AMC_A_DIV:  amc_decode = AMC_R_DIV;
			`AMC_A_SOI:  amc_decode = AMC_R_SOI;
			`AMC_A_RES:  amc_decode = AMC_R_RES;
			`AMC_A_PREV: amc_decode = AMC_R_PREV;
			`AMC_A_STAT: amc_decode = AMC_R_STAT;
			`AMC_A_EN:   amc_decode = AMC_R_EN;
			`AMC_A_CLR:  amc_decode = AMC_R_CLR;
			default:     amc_decode = AMC_R_NONE;
		endcase
	endfunction
endpackage

// >>> logic/amc_seq_if.sv
// link between the control register and the conversion sequencer
`timescale 1ns/100ps
interface amc_seq_if #(
	parameter int RES_W = 10,
	parameter int DIV_W = 6
);
	logic             on;
	logic             cs;
	logic             go;
	logic             rc_tick;
	logic [DIV_W-1:0] div;
	logic [RES_W-1:0] code;
	logic             busy;
	logic             done;
	logic             abort;
	logic [RES_W-1:0] result;

	modport ctl (output on, cs, go, rc_tick, div, code,
		input busy, done, abort, result);
	modport seq (input on, cs, go, rc_tick, div, code,
		output busy, done, abort, result);
endinterface

// >>> logic/amc_seq.sv
// successive approximation sequencer, one code bit per conversion tick
`timescale 1ns/100ps
module amc_seq #(
	parameter int RES_W = 10,
	parameter int DIV_W = 6
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	amc_seq_if.seq    sif
);
	localparam int IW = $clog2(RES_W);

	typedef struct packed {
		amc_pkg::amc_seq_st_e st;
		logic [IW-1:0]        idx;
		logic [RES_W-1:0]     acc;
		logic [DIV_W-1:0]     cnt;
		logic                 done;
		logic                 abort;
		logic [RES_W-1:0]     result;
	} amc_seq_s;

	amc_seq_s q;
	amc_seq_s n;
	logic     tick;

	// next state: tick source, bit decisions, abort on start loss
	always_comb begin
		n = q;
		n.done = 1'b0;
		n.abort = 1'b0;
		tick = sif.cs ? sif.rc_tick : (q.cnt == sif.div);
		unique case (q.st)
			amc_pkg::AMC_S_IDLE: begin
				n.cnt = '0;
				// no start in the done cycle: start bit not yet cleared
				if (sif.on && sif.go && !q.done) begin
					n.st = amc_pkg::AMC_S_CONV;
					n.idx = IW'(RES_W - 1);
					n.acc = '0;
				end
			end
			amc_pkg::AMC_S_CONV: begin
				if (!(sif.on && sif.go)) begin
					n.st = amc_pkg::AMC_S_IDLE;
					n.abort = 1'b1;
					n.result = q.acc;
				end else begin
					if (!sif.cs) begin
						n.cnt = tick ? '0 : q.cnt + 1'b1;
					end
					if (tick) begin
						n.acc[q.idx] = sif.code[q.idx];
						if (q.idx == '0) begin
							n.st = amc_pkg::AMC_S_IDLE;
							n.done = 1'b1;
							n.result = n.acc;
						end else begin
							n.idx = q.idx - 1'b1;
						end
					end
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// outputs to the control register
	assign sif.busy = (q.st == amc_pkg::AMC_S_CONV);
	assign sif.done = q.done;
	assign sif.abort = q.abort;
	assign sif.result = q.result;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	start_go_a: assert property ($rose(sif.busy) |-> $past(sif.go && sif.on))
		else $error("sequencer started without start bit");
	off_idle_a: assert property (!sif.on |=> q.st == amc_pkg::AMC_S_IDLE)
		else $error("sequencer ran while converter off");
	rc_hold_a: assert property ((sif.busy && sif.cs && !sif.rc_tick
		&& sif.go && sif.on) |=> $stable(q.idx) && $stable(q.acc))
		else $error("bit resolved without rc tick");
	div_hold_a: assert property ((sif.busy && !sif.cs && q.cnt != sif.div
		&& sif.go && sif.on) |=> $stable(q.idx)
		&& q.cnt == $past(q.cnt) + 1'b1)
		else $error("divider tick came early");
endmodule

// >>> logic/amc_top.sv
// converter main control register with axi4-lite slave and interrupt
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "amc_cfg.svh"
module amc_top #(
	parameter int RES_W = `AMC_RES_W,
	parameter int DIV_W = `AMC_DIV_W
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic [15:0]      s_axi_awaddr_i,
	input  wire logic             s_axi_awvalid_i,
	output logic                  s_axi_awready_o,
	input  wire logic [31:0]      s_axi_wdata_i,
	input  wire logic [3:0]       s_axi_wstrb_i,
	input  wire logic             s_axi_wvalid_i,
	output logic                  s_axi_wready_o,
	output logic [1:0]            s_axi_bresp_o,
	output logic                  s_axi_bvalid_o,
	input  wire logic             s_axi_bready_i,
	input  wire logic [15:0]      s_axi_araddr_i,
	input  wire logic             s_axi_arvalid_i,
	output logic                  s_axi_arready_o,
	output logic [31:0]           s_axi_rdata_o,
	output logic [1:0]            s_axi_rresp_o,
	output logic                  s_axi_rvalid_o,
	input  wire logic             s_axi_rready_i,
	input  wire logic             rc_tick_i,
	input  wire logic [RES_W-1:0] code_i,
	input  wire logic             thr_flag_i,
	output logic                  adc_on_o,
	output logic                  go_o,
	output logic                  conv_done_o,
	output logic                  irq_o
);
	generate
		if (RES_W < 2 || RES_W > 16 || DIV_W < 1 || DIV_W > 8) begin : g_chk
			$error("amc_top: RES_W 2..16 and DIV_W 1..8 only");
		end
	endgenerate

	typedef struct packed {
		logic             awready;
		logic             wready;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic             aw_full;
		logic [15:0]      awaddr;
		logic             w_full;
		logic [7:0]       wdata;
		logic             wstb;
		logic             on;
		logic             repeat_conversion;
		logic             cs;
		logic             fm;
		logic             go;
		logic             stop;
		logic             stop_on_interrupt;
		logic [DIV_W-1:0] div;
		logic [RES_W-1:0] res;
		logic [RES_W-1:0] prev;
		logic [2:0]       stat;
		logic [2:0]       en;
		logic             irq;
		logic             done;
	} amc_top_s;

	amc_top_s             q;
	amc_top_s             n;
	amc_pkg::amc_reg_e    wsel;
	amc_pkg::amc_reg_e    rsel;
	logic                 do_wr;
	logic                 wr_main;
	logic                 wr_go_set;
	logic                 wr_go_clr;
	logic [2:0]           clr_mask;
	logic [2:0]           ev;

	amc_seq_if #(.RES_W(RES_W), .DIV_W(DIV_W)) sif ();

	amc_seq #(.RES_W(RES_W), .DIV_W(DIV_W)) u_seq (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.sif     (sif)
	);

	// result alignment into a 16-bit field
	function automatic logic [15:0] align(input logic [RES_W-1:0] v,
		input logic right);
		align = right ? 16'(v) : (16'(v) << (16 - RES_W));
	endfunction

	// settings towards the sequencer
	assign sif.on = q.on;
	assign sif.cs = q.cs;
	assign sif.go = q.go;
	assign sif.div = q.div;
	assign sif.rc_tick = rc_tick_i;
	assign sif.code = code_i;

	// bus handshakes, register writes, start bit and events
	always_comb begin
		n = q;
		n.done = 1'b0;
		wsel = amc_pkg::amc_decode(q.awaddr);
		rsel = amc_pkg::amc_decode(s_axi_araddr_i);
		if (s_axi_awvalid_i && q.awready) begin
			n.aw_full = 1'b1;
			n.awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && q.wready) begin
			n.w_full = 1'b1;
			n.wdata = s_axi_wdata_i[7:0];
			n.wstb = s_axi_wstrb_i[0];
		end
		if (q.bvalid && s_axi_bready_i) begin
			n.bvalid = 1'b0;
		end
		do_wr = q.aw_full && q.w_full && !q.bvalid;
		if (do_wr) begin
			n.aw_full = 1'b0;
			n.w_full = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = (wsel == amc_pkg::AMC_R_NONE) ?
				`AMC_RESP_ERR : `AMC_RESP_OK;
		end
		wr_main = do_wr && q.wstb && wsel == amc_pkg::AMC_R_MAIN;
		wr_go_set = wr_main && q.wdata[`AMC_B_GO];
		wr_go_clr = wr_main && !q.wdata[`AMC_B_GO];
		// unimplemented bits are simply not stored
		if (wr_main) begin
			n.on = q.wdata[`AMC_B_ON];
			n.repeat_conversion = q.wdata[`AMC_B_REPEAT];
			n.cs = q.wdata[`AMC_B_CS];
			n.fm = q.wdata[`AMC_B_FMT];
		end
		if (do_wr && q.wstb && wsel == amc_pkg::AMC_R_DIV) begin
			n.div = q.wdata[DIV_W-1:0];
		end
		if (do_wr && q.wstb && wsel == amc_pkg::AMC_R_SOI) begin
			n.stop_on_interrupt = q.wdata[0];
		end
		if (do_wr && q.wstb && wsel == amc_pkg::AMC_R_EN) begin
			n.en = q.wdata[2:0];
		end
		clr_mask = (do_wr && q.wstb && wsel == amc_pkg::AMC_R_CLR) ?
			q.wdata[2:0] : 3'h0;
		// results; an abort moves only the partial code
		if (sif.done) begin
			n.prev = q.res;
			n.res = sif.result;
			n.done = 1'b1;
		end
		if (sif.abort) begin
			n.res = sif.result;
		end
		if (thr_flag_i && q.stop_on_interrupt && q.go) begin
			n.stop = 1'b1;
		end
		if (sif.done && (!q.repeat_conversion || n.stop)) begin
			n.go = 1'b0;
		end
		if (wr_go_clr) begin
			n.go = 1'b0;
		end
		if (wr_go_set) begin
			n.go = 1'b1;
			n.stop = 1'b0;
		end
		if (!n.on) begin
			n.go = 1'b0;
		end
		if (!n.go) begin
			n.stop = 1'b0;
		end
		// sticky events, set beats clear
		ev = '0;
		ev[`AMC_EV_DONE] = sif.done;
		ev[`AMC_EV_THR] = thr_flag_i;
		ev[`AMC_EV_ABORT] = sif.abort;
		n.stat = (q.stat & ~clr_mask) | ev;
		n.irq = |(n.stat & n.en);
		// read channel
		if (q.rvalid && s_axi_rready_i) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && q.arready) begin
			n.rvalid = 1'b1;
			n.rresp = `AMC_RESP_OK;
			unique case (rsel)
				amc_pkg::AMC_R_MAIN: n.rdata = {24'h0, q.on, q.repeat_conversion, 1'b0,
					q.cs, 1'b0, q.fm, 1'b0, q.go};
				amc_pkg::AMC_R_DIV:  n.rdata = 32'(q.div);
				amc_pkg::AMC_R_SOI:  n.rdata = {31'h0, q.stop_on_interrupt};
				amc_pkg::AMC_R_RES:  n.rdata = {16'h0, align(q.res, q.fm)};
				amc_pkg::AMC_R_PREV: n.rdata = {16'h0, align(q.prev, q.fm)};
				amc_pkg::AMC_R_STAT: n.rdata = {29'h0, q.stat};
				amc_pkg::AMC_R_EN:   n.rdata = {29'h0, q.en};
				amc_pkg::AMC_R_CLR:  n.rdata = 32'h0;
				amc_pkg::AMC_R_NONE: begin
					n.rdata = 32'h0;
					n.rresp = `AMC_RESP_ERR;
				end
			endcase
		end
		n.awready = !n.aw_full && !n.bvalid;
		n.wready = !n.w_full && !n.bvalid;
		n.arready = !n.rvalid;
	end

	// state register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// outputs, all from the state register
	assign s_axi_awready_o = q.awready;
	assign s_axi_wready_o = q.wready;
	assign s_axi_bvalid_o = q.bvalid;
	assign s_axi_bresp_o = q.bresp;
	assign s_axi_arready_o = q.arready;
	assign s_axi_rvalid_o = q.rvalid;
	assign s_axi_rresp_o = q.rresp;
	assign s_axi_rdata_o = q.rdata;
	assign adc_on_o = q.on;
	assign go_o = q.go;
	assign conv_done_o = q.done;
	assign irq_o = q.irq;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence s_rd_main;
		s_axi_arvalid_i && q.arready && rsel == amc_pkg::AMC_R_MAIN;
	endsequence
	sequence s_rd_res;
		s_axi_arvalid_i && q.arready && rsel == amc_pkg::AMC_R_RES;
	endsequence
	sequence s_sw_abort;
		wr_go_clr && sif.busy ##1 sif.busy;
	endsequence

	on_go_a: assert property (!q.on |-> !q.go)
		else $error("start bit set while converter off");
	one_shot_a: assert property ((sif.done && !q.repeat_conversion && !wr_go_set)
		|=> !q.go)
		else $error("start bit kept after single conversion");
	repeat_go_a: assert property ((sif.done && q.repeat_conversion && q.go && !q.stop
		&& !(thr_flag_i && q.stop_on_interrupt) && !wr_main) |=> q.go)
		else $error("start bit lost in repeat mode");
	thr_stop_a: assert property ((sif.done && q.go && !wr_go_set
		&& (q.stop || (thr_flag_i && q.stop_on_interrupt))) |=> !q.go)
		else $error("repeat not stopped by threshold");
	sw_abort_a: assert property (s_sw_abort |=> sif.abort)
		else $error("software clear did not abort");
	abort_res_a: assert property (sif.abort |=> q.res == $past(sif.result)
		&& !$rose(q.stat[`AMC_EV_DONE]))
		else $error("abort result or flag wrong");
	go_read_a: assert property (s_rd_main |=> s_axi_rdata_o[0] == $past(q.go))
		else $error("start bit read mismatch");
	resv_zero_a: assert property (s_rd_main |=> s_axi_rdata_o[5] == 1'b0
		&& s_axi_rdata_o[3] == 1'b0 && s_axi_rdata_o[1] == 1'b0
		&& s_axi_rdata_o[31:8] == 24'h0)
		else $error("unimplemented bits read nonzero");
	fmt_right_a: assert property ((s_rd_res and q.fm)
		|=> s_axi_rdata_o[15:0] == 16'($past(q.res)))
		else $error("right justified result wrong");
	fmt_left_a: assert property ((s_rd_res and !q.fm)
		|=> s_axi_rdata_o[15:16-RES_W] == $past(q.res))
		else $error("left justified result wrong");
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the converter main control register block
`timescale 1ns/100ps
`include "amc_cfg.svh"
module tb_top;
	logic        clk_i, rst_b_i, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, rc_tick, thr;
	logic        adc_on, go, done, irq, rc_run;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic [9:0]  code;
	int          err_count, compares, done_cnt;

	amc_top amc_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .rc_tick_i(rc_tick), .code_i(code),
		.thr_flag_i(thr), .adc_on_o(adc_on), .go_o(go),
		.conv_done_o(done), .irq_o(irq));

	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// completion pulse counter and rc tick source, one pulse every 2 clocks
	always @(posedge clk_i) begin
		if (done === 1'b1)
			done_cnt++;
		rc_tick <= rc_run && !rc_tick;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic hang(input string nm);
		err_count++;
		$display("FAIL %s expected answer seen timeout", nm);
		conclude();
	endtask

	// one write; address and data offered together, each released when taken
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input logic [1:0] er);
		bit ta, tw, ga, gw, gb;
		int n;
		@(posedge clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		ga = 0;
		gw = 0;
		gb = 0;
		for (n = 0; n < 100 && !gb; n++) begin
			@(negedge clk_i);
			ta = awvalid && awready;
			tw = wvalid && wready;
			gb = bvalid && bready;
			if (gb)
				chk("bresp", {30'h0, er}, {30'h0, bresp});
			@(posedge clk_i);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (gb)
				bready <= 1'b0;
		end
		if (!gb)
			hang("write");
	endtask

	// one read; rready held until the data is sampled
	task automatic rdw(input logic [15:0] a);
		bit ta, gr;
		int n;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		gr = 0;
		for (n = 0; n < 100 && !gr; n++) begin
			@(negedge clk_i);
			ta = arvalid && arready;
			gr = rvalid && rready;
			rd = rdata;
			rs = rresp;
			@(posedge clk_i);
			if (ta)
				arvalid <= 1'b0;
			if (gr)
				rready <= 1'b0;
		end
		if (!gr)
			hang("read");
	endtask

	task automatic rchk(input string nm, input logic [15:0] a,
		input logic [31:0] e);
		rdw(a);
		chk(nm, e, rd);
	endtask

	// waits for the completion count to reach tgt; returns cycles spent
	task automatic wait_done(input int tgt, output int n);
		for (n = 0; n < 3000 && done_cnt < tgt; n++)
			@(posedge clk_i);
		if (done_cnt < tgt)
			hang("conv_done");
	endtask

	task automatic t_loose();
		rchk("main reset", `AMC_A_MAIN, 32'h0);
		wr(`AMC_A_MAIN, 8'hEE, `AMC_RESP_OK);
		rchk("main loose bits", `AMC_A_MAIN, 32'hC4);
		chk("adc_on", 32'h1, {31'h0, adc_on});
		wr(`AMC_A_MAIN, 8'h01, `AMC_RESP_OK);
		rchk("start while off", `AMC_A_MAIN, 32'h0);
		chk("adc off", 32'h0, {31'h0, adc_on});
	endtask

	task automatic t_single();
		int n;
		wr(`AMC_A_DIV, 8'h3F, `AMC_RESP_OK);
		wr(`AMC_A_EN, 8'h01, `AMC_RESP_OK);
		code <= 10'h2A5;
		wr(`AMC_A_MAIN, 8'h85, `AMC_RESP_OK);
		rchk("start busy", `AMC_A_MAIN, 32'h85);
		wait_done(1, n);
		chk("divided clock slow", 32'h1, {31'h0, n > 600});
		rchk("start cleared", `AMC_A_MAIN, 32'h84);
		rchk("result right", `AMC_A_RES, 32'h2A5);
		chk("irq raised", 32'h1, {31'h0, irq});
		rchk("status done", `AMC_A_STAT, 32'h1);
		wr(`AMC_A_CLR, 8'h07, `AMC_RESP_OK);
		chk("irq cleared", 32'h0, {31'h0, irq});
	endtask

	task automatic t_rc_left();
		int n;
		code <= 10'h13C;
		wr(`AMC_A_MAIN, 8'h91, `AMC_RESP_OK);
		repeat (300) @(posedge clk_i);
		chk("no rc no done", 32'h1, done_cnt);
		chk("go held", 32'h1, {31'h0, go});
		rc_run <= 1'b1;
		wait_done(2, n);
		rc_run <= 1'b0;
		rchk("result left", `AMC_A_RES, 32'h4F00);
		rchk("prev left", `AMC_A_PREV, 32'hA940);
		wr(`AMC_A_CLR, 8'h07, `AMC_RESP_OK);
	endtask

	task automatic t_repeat();
		int n;
		wr(`AMC_A_DIV, 8'h00, `AMC_RESP_OK);
		wr(`AMC_A_SOI, 8'h01, `AMC_RESP_OK);
		wr(`AMC_A_MAIN, 8'hC5, `AMC_RESP_OK);
		wait_done(3, n);
		repeat (3) @(posedge clk_i);
		chk("go rearmed", 32'h1, {31'h0, go});
		wait_done(4, n);
		thr <= 1'b1;
		@(posedge clk_i);
		thr <= 1'b0;
		wait_done(5, n);
		repeat (3) @(posedge clk_i);
		chk("go stopped", 32'h0, {31'h0, go});
		repeat (100) @(posedge clk_i);
		chk("no more runs", 32'h5, done_cnt);
		rchk("main after stop", `AMC_A_MAIN, 32'hC4);
		rchk("status thr", `AMC_A_STAT, 32'h3);
		wr(`AMC_A_CLR, 8'h07, `AMC_RESP_OK);
	endtask

	task automatic t_abort();
		wr(`AMC_A_DIV, 8'h3F, `AMC_RESP_OK);
		wr(`AMC_A_MAIN, 8'h85, `AMC_RESP_OK);
		repeat (200) @(posedge clk_i);
		wr(`AMC_A_MAIN, 8'h84, `AMC_RESP_OK);
		repeat (1000) @(posedge clk_i);
		chk("abort no done", 32'h5, done_cnt);
		rchk("abort partial", `AMC_A_RES, 32'h100);
		rchk("abort status", `AMC_A_STAT, 32'h4);
		chk("abort masked", 32'h0, {31'h0, irq});
		wr(`AMC_A_EN, 8'h04, `AMC_RESP_OK);
		chk("abort irq", 32'h1, {31'h0, irq});
		rchk("abort start", `AMC_A_MAIN, 32'h84);
	endtask

	task automatic t_unmapped();
		wr(16'h0000, 8'h55, `AMC_RESP_ERR);
		rdw(16'h0000);
		chk("unmapped resp", {30'h0, `AMC_RESP_ERR}, {30'h0, rs});
		chk("unmapped data", 32'h0, rd);
		rchk("clear reads 0", `AMC_A_CLR, 32'h0);
	endtask

	// reset, then the scenarios in order
	initial begin
		{rst_b_i, awvalid, wvalid, bready, arvalid, rready} = '0;
		{thr, rc_run, awaddr, araddr, wdata} = '0;
		wstrb = 4'h1;
		code = 10'h0;
		err_count = 0;
		compares = 0;
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		t_loose();
		t_single();
		t_rc_left();
		t_repeat();
		t_abort();
		t_unmapped();
		conclude();
	end
endmodule
